/* sfwpe_core.sv */
// Program, erase, burst-wrap and continuous-read control of a serial flash.
//
// Summary of operation
// RQ1: Wrap command: 77h, 24 dummy, wrap byte.
// RQ2: Only wrap byte bits 6 to 4 kept.
// RQ3: Wrap enabled gives 8/16/32/64-byte sections.
// RQ4: Wrap disable bit set means linear; resets set.
// RQ5: Wrap setting holds until next wrap command.
// RQ6: Host should disable wrap after its reset.
// RQ7: Skip bits 10 drop next opcode; else normal.
// RQ8: Reserved mode bits change nothing.
// RQ9: Reset sequence sets release bit, ends mode.
// RQ10: Reset sequence: FFh quad, FFFFh dual.
// RQ11: Host sends reset sequence first after reset.
// RQ12: Page program: 02h, address, data bytes.
// RQ13: Program needs write enable latch set.
// RQ14: Page index wraps at 256-byte boundary.
// RQ15: Select must rise on byte boundary.
// RQ16: Self-timed program cycle shows busy.
// RQ17: Program end clears write enable latch.
// RQ18: Protected page is never programmed.
// RQ19: 32h programs on four lanes, needs quad enable.
// RQ20: 20h plus address erases 4K sector.
// RQ21: Erase cycle busy, then latch clears.
// RQ22: Protected sector is never erased.
// RQ23: Bits sampled on rising clock, MSB first.
`timescale 1ns/1ns
`default_nettype none
module sfwpe_core
  import sfwpe_pkg::*;
#(
  parameter int P_PP_CYCLES = T_PP_US * CLK_MHZ,
  parameter int P_SE_CYCLES = T_SE_US * CLK_MHZ
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  input  wire logic        i_link_clk,
  input  wire logic        i_cs_n,
  input  wire logic [3:0]  i_io,
  input  wire logic        i_wel_set,
  input  wire logic        i_quad_lane_enable,
  input  wire logic        i_protect_complement,
  input  wire logic        i_protect_granularity,
  input  wire logic        i_protect_top_bottom,
  input  wire logic        i_protect_range_bit2,
  input  wire logic        i_protect_range_bit1,
  input  wire logic        i_protect_range_bit0,
  input  wire logic        i_mode_strobe,
  input  wire logic [7:0]  i_continuous_read_byte,
  input  wire logic        i_mode_dual,
  output logic             o_busy,
  output logic             o_write_enable_latch,
  output logic [2:0]       o_wrap_setting_bits,
  output logic [6:0]       o_wrap_span,
  output logic             o_opcode_skip,
  output logic             o_buf_we,
  output logic [7:0]       o_buf_index,
  output logic [7:0]       o_buf_data,
  output logic             o_array_start,
  output logic             o_array_erase,
  output logic [23:0]      o_array_addr,
  output logic             o_cmd_discard
);
  sfwpe_link_if lnk ();

  sfwpe_link_front u_front (
    .i_ref_clk  (i_ref_clk),
    .i_reset    (i_reset),
    .i_link_clk (i_link_clk),
    .i_cs_n     (i_cs_n),
    .i_io       (i_io),
    .link       (lnk)
  );

  sfwpe_state_type state_reg;
  sfwpe_state_type state_next;
  sfwpe_op_type    op_reg;
  sfwpe_op_type    op_next;
  logic [7:0]        shift_reg;
  logic [2:0]        bit_reg;
  logic [1:0]        byte_reg;
  logic [23:0]       addr_reg;
  logic [7:0]        index_reg;
  logic              have_data_reg;
  logic              wel_reg;
  logic              busy_reg;
  logic [BUSY_W-1:0] busy_cnt_reg;
  logic [2:0]        wrap_reg;
  logic [7:0]        mode_reg;
  logic              mode_dual_reg;
  logic [4:0]        crm_cnt_reg;
  logic              crm_ones_reg;
  logic              buf_we_reg;
  logic [7:0]        buf_index_reg;
  logic [7:0]        buf_data_reg;
  logic              start_reg;
  logic              discard_reg;

  // Lane width: wrap payload and quad program data use four lanes.
  wire       quad_lane  = (state_reg == ST_WRAP) ||
                          (state_reg == ST_DATA && op_reg == OP_QPROG); // [RQ19]
  wire [7:0] shift_next = quad_lane ? {shift_reg[3:0], lnk.io}
                                    : {shift_reg[6:0], lnk.io[0]}; // [RQ23]
  wire [2:0] bit_next   = bit_reg + (quad_lane ? STEP_QUAD : STEP_ONE);
  wire       byte_done  = lnk.rise && (bit_next == 3'h0);
  wire [23:0] addr_full = {addr_reg[15:0], shift_next};

  // Protected region size from the protection bits; zero means none.
  wire [2:0]  prot_bp   = {i_protect_range_bit2, i_protect_range_bit1, i_protect_range_bit0};
  wire [2:0]  sec_bp    = (prot_bp > SEC_MAX_BP) ? SEC_MAX_BP : prot_bp;
  wire [21:0] sec_size  = (prot_bp == 3'h0) ? 22'h0 : (22'h1 << (SEC_SHIFT + 32'(sec_bp)));
  wire [21:0] blk_size  = (prot_bp == 3'h0) ? 22'h0 : (prot_bp >= ALL_BP) ? FLASH_BYTES
                        : (22'h1 << (BLK_SHIFT + 32'(prot_bp)));
  wire [21:0] prot_size = i_protect_granularity ? sec_size : blk_size;
  wire [21:0] addr_byte = {1'b0, addr_full[20:0]};
  wire        in_region = i_protect_top_bottom
                        ? (addr_byte >= FLASH_BYTES - prot_size)
                        : (addr_byte < prot_size);
  wire        prot_hit  = ((prot_size != 22'h0) && in_region)
                        ^ i_protect_complement; // [RQ18] [RQ22]

  // Command acceptance checks at the end of the opcode byte.
  wire is_prog   = (shift_next == OPC_PROG);
  wire is_qprog  = (shift_next == OPC_QPROG);
  wire is_erase  = (shift_next == OPC_ERASE);
  wire is_write  = is_prog || is_qprog || is_erase;
  wire write_ok  = wel_reg && !busy_reg &&
                   (!is_qprog || i_quad_lane_enable); // [RQ13] [RQ19] [RQ20]

  // A program ends on a byte boundary with data; erase right after address.
  wire prog_end  = lnk.cs_rise && state_reg == ST_DATA &&
                   bit_reg == 3'h0 && have_data_reg; // [RQ15] [RQ12]
  wire erase_end = lnk.cs_rise && state_reg == ST_TAIL; // [RQ15] [RQ21]
  wire go        = prog_end || erase_end;
  wire bad_end   = lnk.cs_rise && !go && op_reg != OP_WRAP &&
                   (state_reg == ST_DATA || state_reg == ST_ADDR);

  // Continuous-read reset sequence: all ones on lane 0 for 8 or 16 clocks.
  wire [4:0] crm_cnt_next = crm_cnt_reg + 5'h01;
  wire       crm_ones_next = crm_ones_reg && lnk.io[0];
  wire [4:0] crm_need = mode_dual_reg ? CRM_DUAL_CLOCKS : CRM_QUAD_CLOCKS; // [RQ10]
  wire       crm_release = state_reg == ST_CRM && lnk.rise &&
                           crm_ones_next && crm_cnt_next == crm_need;
  wire       skip_active = mode_reg[MODE_SKIP_LO +: 2] == MODE_SKIP_CODE;

  // Busy timer end of self-timed cycle.
  wire busy_end = busy_reg && busy_cnt_reg == '0;

  // Frame sequencing.
  always_comb begin
    state_next = state_reg;
    op_next    = op_reg;
    if (lnk.cs_rise) begin
      state_next = ST_IDLE;
    end else if (lnk.cs_fall) begin
      // In continuous mode the frame starts without an opcode; here it
      // only watches for the release pattern, reads are served elsewhere.
      state_next = skip_active ? ST_CRM : ST_OPCODE; // [RQ7]
    end else begin
      unique case (state_reg)
        ST_IDLE, ST_SKIP, ST_DATA: begin
          state_next = state_reg;
        end
        ST_OPCODE: begin
          if (byte_done) begin
            if (shift_next == OPC_WRAP && !busy_reg) begin
              state_next = ST_WRAP; // [RQ1]
              op_next    = OP_WRAP;
            end else if (is_write && write_ok) begin
              state_next = ST_ADDR;
              op_next    = is_prog ? OP_PROG : is_qprog ? OP_QPROG : OP_ERASE;
            end else begin
              state_next = ST_SKIP;
            end
          end
        end
        ST_ADDR: begin
          if (byte_done && byte_reg == ADDR_LAST_BYTE) begin
            if (prot_hit) begin
              state_next = ST_SKIP;
            end else begin
              state_next = (op_reg == OP_ERASE) ? ST_TAIL : ST_DATA;
            end
          end
        end
        ST_WRAP: begin
          if (byte_done && byte_reg == WRAP_LAST_BYTE) begin
            state_next = ST_SKIP;
          end
        end
        ST_TAIL: begin
          // Any extra clock after the address breaks the erase frame.
          if (lnk.rise) begin
            state_next = ST_SKIP; // [RQ15]
          end
        end
        ST_CRM: begin
          if (crm_release || (lnk.rise && !lnk.io[0])) begin
            state_next = ST_SKIP;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_reg <= ST_IDLE;
      op_reg    <= OP_PROG;
    end else begin
      state_reg <= state_next;
      op_reg    <= op_next;
    end
  end

  // Bit and byte counters restart with every frame.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || lnk.cs_fall) begin
      shift_reg <= 8'h00;
      bit_reg   <= 3'h0;
      byte_reg  <= 2'h0;
      have_data_reg <= 1'b0;
    end else if (lnk.rise) begin
      shift_reg <= shift_next;
      bit_reg   <= bit_next;
      if (byte_done && state_reg != state_next) begin
        byte_reg <= 2'h0;
      end else if (byte_done) begin
        byte_reg <= byte_reg + 2'h1;
      end
      if (byte_done && state_reg == ST_DATA) begin
        have_data_reg <= 1'b1;
      end
    end
  end

  // Address capture; the page index starts at the low address byte.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      addr_reg  <= 24'h000000;
      index_reg <= 8'h00;
    end else if (state_reg == ST_ADDR && byte_done) begin
      addr_reg  <= addr_full;
      index_reg <= shift_next;
    end else if (state_reg == ST_DATA && byte_done) begin
      // Eight-bit index rolls over inside the page on its own.
      index_reg <= index_reg + 8'h01; // [RQ14]
    end
  end

  // Data bytes go to the page buffer; a rolled-over index overwrites older data.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      buf_we_reg    <= 1'b0;
      buf_index_reg <= 8'h00;
      buf_data_reg  <= 8'h00;
    end else begin
      buf_we_reg <= state_reg == ST_DATA && byte_done && !lnk.cs_rise; // [RQ14]
      if (state_reg == ST_DATA && byte_done) begin
        buf_index_reg <= index_reg;
        buf_data_reg  <= shift_next;
      end
    end
  end

  // Start pulse, discard pulse and operation descriptor for the array.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      start_reg     <= 1'b0;
      discard_reg   <= 1'b0;
      o_array_erase <= 1'b0;
      o_array_addr  <= 24'h000000;
    end else begin
      start_reg   <= go; // [RQ16] [RQ21]
      discard_reg <= bad_end || (state_next == ST_SKIP &&
                     state_reg != ST_SKIP && state_reg != ST_WRAP &&
                     state_reg != ST_CRM && !lnk.cs_fall &&
                     (state_reg != ST_OPCODE || is_write));
      if (go) begin
        o_array_erase <= erase_end;
        o_array_addr  <= addr_reg;
      end
    end
  end

  // Self-timed program or erase cycle; status reads stay free meanwhile.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      busy_reg     <= 1'b0;
      busy_cnt_reg <= '0;
    end else if (go) begin
      busy_reg     <= 1'b1; // [RQ16] [RQ21]
      busy_cnt_reg <= erase_end ? BUSY_W'(P_SE_CYCLES - 1) : BUSY_W'(P_PP_CYCLES - 1);
    end else if (busy_end) begin
      busy_reg <= 1'b0;
    end else if (busy_reg) begin
      busy_cnt_reg <= busy_cnt_reg - 1'b1;
    end
  end

  // A latch set in the same cycle as the cycle-end clear wins.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      wel_reg <= 1'b0;
    end else if (i_wel_set) begin
      wel_reg <= 1'b1;
    end else if (busy_end) begin
      wel_reg <= 1'b0; // [RQ17] [RQ21]
    end
  end

  // Wrap setting is taken only when the eighth wrap bit arrives, so a
  // short frame leaves the old setting in force.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      wrap_reg <= WRAP_RESET; // [RQ4]
    end else if (state_reg == ST_WRAP && byte_done && byte_reg == WRAP_LAST_BYTE) begin
      wrap_reg <= shift_next[WRAP_LO +: 3]; // [RQ1] [RQ2] [RQ5]
    end
  end

  // Continuous-read byte from the read path; only the skip bits matter.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      mode_reg      <= MODE_RESET;
      mode_dual_reg <= 1'b0;
    end else if (i_mode_strobe) begin
      mode_reg      <= i_continuous_read_byte; // [RQ7] [RQ8]
      mode_dual_reg <= i_mode_dual;
    end else if (crm_release) begin
      mode_reg[MODE_RELEASE_BIT] <= 1'b1; // [RQ9]
    end
  end

  // Release pattern counter for the continuous-read reset sequence.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || lnk.cs_fall) begin
      crm_cnt_reg  <= 5'h00;
      crm_ones_reg <= 1'b1;
    end else if (state_reg == ST_CRM && lnk.rise) begin
      crm_cnt_reg  <= crm_cnt_next;
      crm_ones_reg <= crm_ones_next; // [RQ10]
    end
  end

  // Registered status outputs.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_wrap_setting_bits <= WRAP_RESET;
      o_wrap_span         <= 7'h00;
      o_opcode_skip       <= 1'b0;
    end else begin
      o_wrap_setting_bits <= wrap_reg;
      // Zero span means linear reads with no wrapping.
      o_wrap_span   <= wrap_reg[0] ? 7'h00 : sfwpe_wrap_span(wrap_reg[2:1]); // [RQ3] [RQ4]
      o_opcode_skip <= skip_active; // [RQ7]
    end
  end

  assign o_busy               = busy_reg;
  assign o_write_enable_latch = wel_reg;
  assign o_buf_we             = buf_we_reg;
  assign o_buf_index          = buf_index_reg;
  assign o_buf_data           = buf_data_reg;
  assign o_array_start        = start_reg;
  assign o_cmd_discard        = discard_reg;
endmodule
`default_nettype wire

/* sfwpe_core_chk.sv */
// Concurrent checks on the sequencer's top-level ports.
`timescale 1ns/1ns
`default_nettype none
module sfwpe_core_chk
  import sfwpe_pkg::*;
#(
  parameter int P_PP_CYCLES = 20,
  parameter int P_SE_CYCLES = 40
) (
  input wire logic       i_ref_clk,
  input wire logic       i_reset,
  input wire logic       i_cs_n,
  input wire logic       i_wel_set,
  input wire logic       i_mode_strobe,
  input wire logic [7:0] i_continuous_read_byte,
  input wire logic       o_busy,
  input wire logic       o_write_enable_latch,
  input wire logic [2:0] o_wrap_setting_bits,
  input wire logic [6:0] o_wrap_span,
  input wire logic       o_opcode_skip,
  input wire logic       o_array_start,
  input wire logic       o_array_erase,
  input wire logic       o_cmd_discard
);
  int busy_cnt_reg;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  // Counts busy cycles from the start pulse so the length is judged when busy drops.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      busy_cnt_reg <= 0;
    end else if (o_array_start) begin
      busy_cnt_reg <= 1;
    end else if (o_busy) begin
      busy_cnt_reg <= busy_cnt_reg + 1;
    end
  end

  property p_start_busy; o_array_start |-> o_busy; endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("busy missing at start");
  property p_busy_len;
    $fell(o_busy) |-> busy_cnt_reg == (o_array_erase ? P_SE_CYCLES : P_PP_CYCLES);
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy length wrong");
  property p_latch_clear; $fell(o_busy) && !$past(i_wel_set) |-> !o_write_enable_latch;
  endproperty
  a_latch_clear: assert property (p_latch_clear)
    else $error("latch kept after cycle");
  property p_start_wel; o_array_start |-> $past(o_write_enable_latch); endproperty
  a_start_wel: assert property (p_start_wel)
    else $error("start without latch");
  property p_start_idle; o_array_start |-> !$past(o_busy); endproperty
  a_start_idle: assert property (p_start_idle)
    else $error("start while busy");
  property p_start_cs; o_array_start |-> $past(i_cs_n, 2); endproperty
  a_start_cs: assert property (p_start_cs)
    else $error("start before select rose");
  property p_span;
    o_wrap_span == (o_wrap_setting_bits[0] ? 7'h00 :
                    7'h08 << o_wrap_setting_bits[2:1]);
  endproperty
  a_span: assert property (p_span)
    else $error("wrap span wrong");
  property p_wrap_hold; i_cs_n [*8] |-> $stable(o_wrap_setting_bits); endproperty
  a_wrap_hold: assert property (p_wrap_hold)
    else $error("wrap setting changed between frames");
  property p_skip;
    i_mode_strobe |-> ##2
      o_opcode_skip == ($past(i_continuous_read_byte[5:4], 2) == MODE_SKIP_CODE);
  endproperty
  a_skip: assert property (p_skip)
    else $error("skip flag wrong");

  c_prog: cover property (o_array_start && !o_array_erase);
  c_erase: cover property (o_array_start && o_array_erase);
  c_disc: cover property (o_cmd_discard);
  c_skip: cover property ($rose(o_opcode_skip));
endmodule

bind sfwpe_core sfwpe_core_chk #(.P_PP_CYCLES(P_PP_CYCLES), .P_SE_CYCLES(P_SE_CYCLES)) chk (
  .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_cs_n(i_cs_n), .i_wel_set(i_wel_set),
  .i_mode_strobe(i_mode_strobe), .i_continuous_read_byte(i_continuous_read_byte),
  .o_busy(o_busy), .o_write_enable_latch(o_write_enable_latch),
  .o_wrap_setting_bits(o_wrap_setting_bits), .o_wrap_span(o_wrap_span),
  .o_opcode_skip(o_opcode_skip), .o_array_start(o_array_start),
  .o_array_erase(o_array_erase), .o_cmd_discard(o_cmd_discard));
`default_nettype wire

/* sfwpe_host.sv */
// Host-side link driver model for the sequencer's serial pins.
`timescale 1ns/1ns
`default_nettype none
module sfwpe_host (
  output logic       o_link_clk,
  output logic       o_cs_n,
  output logic [3:0] o_io
);
  // The link clock rests low outside frames.
  initial begin
    o_link_clk = 1'b0;
    o_cs_n = 1'b1;
    o_io = 4'h0;
  end

  // Selects the device; the offset keeps link edges apart from the system clock.
  task automatic open_frame();
    #7 o_cs_n = 1'b0;
    #200;
  endtask

  // Data changes while the clock is low, most significant first.
  task automatic shift(input logic [31:0] v, input int nbits, input bit quad);
    int i;
    for (i = nbits; i > 0; i -= (quad ? 4 : 1)) begin
      o_io = quad ? v[i-1 -: 4] : {3'h7, v[i-1]};
      #200 o_link_clk = 1'b1;
      #200 o_link_clk = 1'b0;
    end
  endtask

  // Ends the frame; released lanes flip so a stale value never passes.
  task automatic close_frame();
    #200 o_cs_n = 1'b1;
    o_io = ~o_io;
    #800;
  endtask
endmodule
`default_nettype wire

/* sfwpe_link_front.sv */
// Pin synchroniser and edge finder for the serial link.
`timescale 1ns/1ns
`default_nettype none
module sfwpe_link_front
  import sfwpe_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  input  wire logic       i_link_clk,
  input  wire logic       i_cs_n,
  input  wire logic [3:0] i_io,
  sfwpe_link_if.front     link
);
  logic [5:0] meta_reg;
  logic [5:0] sync_reg;
  logic [5:0] prev_reg;

  // Two flops on every pin; clock, select and data share the same delay,
  // so data is still stable when the sampled clock edge is seen.
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      meta_reg <= 6'h3e;
      sync_reg <= 6'h3e;
      prev_reg <= 6'h3e;
    end else begin
      meta_reg <= {i_link_clk, i_cs_n, i_io};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Edges only look at the second stage and its delayed copy.
  assign link.rise    = sync_reg[5] & ~prev_reg[5] & ~sync_reg[4]; // [RQ23]
  assign link.cs_fall = ~sync_reg[4] & prev_reg[4];
  assign link.cs_rise = sync_reg[4] & ~prev_reg[4];
  assign link.io      = sync_reg[3:0];
endmodule
`default_nettype wire

/* sfwpe_link_if.sv */
// Sampled link signals passed from the pin front end to the sequencer core.
`timescale 1ns/1ns
`default_nettype none
interface sfwpe_link_if;
  logic       rise;
  logic       cs_fall;
  logic       cs_rise;
  logic [3:0] io;
  modport front (output rise, output cs_fall, output cs_rise, output io);
  modport core  (input rise, input cs_fall, input cs_rise, input io);
endinterface
`default_nettype wire

/* sfwpe_pkg.sv */
// Shared constants, types and helpers for the flash program/erase sequencer.
package sfwpe_pkg;
  // Instruction codes handled by the sequencer.
  localparam logic [7:0] OPC_WRAP  = 8'h77;
  localparam logic [7:0] OPC_PROG  = 8'h02;
  localparam logic [7:0] OPC_QPROG = 8'h32;
  localparam logic [7:0] OPC_ERASE = 8'h20;
  // Frame layout counts, in bytes.
  localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
  localparam logic [1:0] WRAP_LAST_BYTE = 2'h3;
  // Lane step sizes per link clock edge.
  localparam logic [2:0] STEP_ONE  = 3'h1;
  localparam logic [2:0] STEP_QUAD = 3'h4;
  // Wrap setting field position and power-up value (wrap disabled).
  localparam int         WRAP_LO    = 4;
  localparam logic [2:0] WRAP_RESET = 3'h1;
  // Continuous-read byte: skip code, release bit and reset value.
  localparam logic [1:0] MODE_SKIP_CODE   = 2'h2;
  localparam int         MODE_SKIP_LO     = 4;
  localparam int         MODE_RELEASE_BIT = 4;
  localparam logic [7:0] MODE_RESET       = 8'h10;
  // Clock counts of the continuous-read reset sequence.
  localparam logic [4:0] CRM_QUAD_CLOCKS = 5'h08;
  localparam logic [4:0] CRM_DUAL_CLOCKS = 5'h10;
  // Self-timed cycle lengths, in microseconds, and the clock rate.
  localparam int CLK_MHZ  = 20;
  localparam int T_PP_US  = 3000;
  localparam int T_SE_US  = 400000;
  localparam int BUSY_W   = 24;
  // Protection geometry: array size and region granularity shifts.
  localparam logic [21:0] FLASH_BYTES = 22'h200000;
  localparam int          SEC_SHIFT   = 11;
  localparam int          BLK_SHIFT   = 15;
  localparam logic [2:0]  SEC_MAX_BP  = 3'h4;
  localparam logic [2:0]  BLK_MAX_BP  = 3'h5;
  localparam logic [2:0]  ALL_BP      = 3'h6;

  typedef enum logic [2:0] {
    ST_IDLE, ST_OPCODE, ST_ADDR, ST_WRAP, ST_DATA, ST_TAIL, ST_SKIP, ST_CRM
  } sfwpe_state_type;

  typedef enum logic [1:0] {OP_PROG, OP_QPROG, OP_ERASE, OP_WRAP} sfwpe_op_type;

  // Wrap section length in bytes for a two-bit length code.
  function automatic logic [6:0] sfwpe_wrap_span(input logic [1:0] len);
    sfwpe_wrap_span = 7'h08 << len;
  endfunction
endpackage

/* sfwpe_tb.sv */
// Self-checking bench for the program/erase sequencer.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import sfwpe_pkg::*;
  localparam int PP = 300;
  localparam int SE = 600;
  logic            clk, rst, write_enable_latch, qe, bp0, prot_off, strobe, dual;
  logic            busy, latch, skip, bwe, start, erase, disc;
  logic [7:0]      crb, bidx, bdat;
  logic [2:0]      wrap;
  logic [6:0]      span;
  logic [23:0]     addr;
  wire logic       lclk, cs_n;
  wire logic [3:0] io;
  int              n_errors, tests_run, n_start, n_disc;
  logic [15:0]     bq[$];

  sfwpe_host host (.o_link_clk(lclk), .o_cs_n(cs_n), .o_io(io));
  sfwpe_core #(.P_PP_CYCLES(PP), .P_SE_CYCLES(SE)) uut (
    .i_ref_clk(clk), .i_reset(rst), .i_link_clk(lclk), .i_cs_n(cs_n), .i_io(io),
    .i_wel_set(write_enable_latch), .i_quad_lane_enable(qe), .i_protect_complement(prot_off),
    .i_protect_granularity(prot_off), .i_protect_top_bottom(prot_off),
    .i_protect_range_bit2(prot_off), .i_protect_range_bit1(prot_off),
    .i_protect_range_bit0(bp0), .i_mode_strobe(strobe), .i_continuous_read_byte(crb),
    .i_mode_dual(dual), .o_busy(busy), .o_write_enable_latch(latch),
    .o_wrap_setting_bits(wrap), .o_wrap_span(span), .o_opcode_skip(skip),
    .o_buf_we(bwe), .o_buf_index(bidx), .o_buf_data(bdat), .o_array_start(start),
    .o_array_erase(erase), .o_array_addr(addr), .o_cmd_discard(disc));

  // A 20 MHz system clock.
  always #25 clk = ~clk;

  // Pulses are collected here so the tasks can judge them after a frame.
  always @(posedge clk) begin
    if (bwe === 1'b1) bq.push_back({bidx, bdat});
    if (start === 1'b1) n_start++;
    if (disc === 1'b1) n_disc++;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %0h, seen %0h", nm, exp, got);
    end
  endtask

  task automatic results();
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Bounded wait for the self-timed cycle; running out ends the run.
  task automatic wait_idle();
    int k;
    for (k = 0; k < 4000 && busy !== 1'b0; k++) @(negedge clk);
    if (busy !== 1'b0) begin
      n_errors++;
      results();
    end
  endtask

  task automatic set_wel();
    @(posedge clk) write_enable_latch <= 1'b1;
    @(posedge clk) write_enable_latch <= 1'b0;
  endtask

  task automatic mode_byte(input logic [7:0] b, input bit d);
    @(posedge clk) begin
      strobe <= 1'b1;
      crb <= b;
      dual <= d;
    end
    @(posedge clk) strobe <= 1'b0;
    repeat (2) @(negedge clk);
  endtask

  // One frame: opcode and address on lane 0, data bytes, then stray bits if asked.
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int nd, input int tail);
    int j;
    host.open_frame();
    host.shift({24'h0, op}, 8, 1'b0);
    host.shift({8'h0, a}, 24, 1'b0);
    for (j = 0; j < nd; j++) host.shift({24'h0, 8'ha0 + j[7:0]}, 8, op == OPC_QPROG);
    if (tail > 0) host.shift(32'h0, tail, 1'b0);
    host.close_frame();
  endtask

  // All-ones frame; each unit is eight clocks on four lanes.
  task automatic crm(input int units);
    int j;
    host.open_frame();
    for (j = 0; j < units; j++) host.shift(32'hffffffff, 32, 1'b1);
    host.close_frame();
  endtask

  task automatic t_wrap();
    int k;
    logic [7:0] wb;
    for (k = 0; k < 5; k++) begin
      wb = (k < 4) ? {1'b1, k[1:0], 5'h0a} : 8'h9f;
      host.open_frame();
      host.shift(32'h77, 8, 1'b0);
      host.shift(32'h0, 24, 1'b1);
      host.shift({24'h0, wb}, 8, 1'b1);
      host.close_frame();
      chk("wrap bits", 32'(wb[6:4]), 32'(wrap));
      chk("wrap span", (k < 4) ? 32'h8 << k : 32'h0, 32'(span));
    end
  endtask

  task automatic t_prog();
    int s;
    s = n_start;
    bq.delete();
    set_wel();
    cmd(OPC_PROG, 24'h0100fe, 3, 0);
    chk("starts", s + 1, n_start);
    chk("erase flag", 0, 32'(erase));
    chk("array addr", 32'h0100fe, 32'(addr));
    chk("bytes", 3, bq.size());
    chk("first byte", 32'hfea0, 32'(bq[0]));
    chk("wrapped byte", 32'h00a2, 32'(bq[2]));
    chk("busy", 1, 32'(busy));
    wait_idle();
    chk("latch", 0, 32'(latch));
    chk("wrap kept", 1, 32'(wrap));
  endtask

  task automatic t_refuse();
    int s;
    int d;
    s = n_start;
    cmd(OPC_PROG, 24'h0100fe, 1, 0);
    set_wel();
    d = n_disc;
    cmd(OPC_PROG, 24'h0100fe, 1, 4);
    cmd(OPC_ERASE, 24'h010000, 0, 8);
    chk("discards", d + 2, n_disc);
    cmd(OPC_QPROG, 24'h0100fe, 1, 0);
    chk("refused starts", s, n_start);
    @(posedge clk) qe <= 1'b1;
    bq.delete();
    cmd(OPC_QPROG, 24'h0100fe, 2, 0);
    chk("quad starts", s + 1, n_start);
    chk("quad byte", 32'hffa1, 32'(bq[1]));
    wait_idle();
  endtask

  task automatic t_protect();
    int s;
    int d;
    set_wel();
    @(posedge clk) bp0 <= 1'b1;
    s = n_start;
    d = n_disc;
    cmd(OPC_PROG, 24'h000010, 1, 0);
    cmd(OPC_ERASE, 24'h001000, 0, 0);
    @(posedge clk) prot_off <= 1'b1;
    cmd(OPC_ERASE, 24'h1f3000, 0, 0);
    chk("protected starts", s, n_start);
    chk("protected discards", d + 3, n_disc);
    @(posedge clk) {bp0, prot_off} <= 2'b00;
  endtask

  task automatic t_erase();
    int s;
    set_wel();
    s = n_start;
    cmd(OPC_ERASE, 24'h1f3000, 0, 0);
    chk("erase starts", s + 1, n_start);
    chk("erase flag", 1, 32'(erase));
    chk("erase addr", 32'h1f3000, 32'(addr));
    chk("busy", 1, 32'(busy));
    wait_idle();
    chk("latch", 0, 32'(latch));
  endtask

  task automatic t_mode();
    logic [7:0] tbl[5] = '{8'hef, 8'h10, 8'h20, 8'hd0, 8'h30};
    int k;
    for (k = 0; k < 5; k++) begin
      mode_byte(tbl[k], 1'b0);
      chk("skip", 32'(tbl[k][5:4] == 2'h2), 32'(skip));
    end
    for (k = 0; k < 2; k++) begin
      mode_byte(8'h20, k[0]);
      crm(k + 1);
      chk("skip released", 0, 32'(skip));
    end
  endtask

  // Reset for four cycles, then the host's first frame is the release sequence.
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {write_enable_latch, qe, bp0, prot_off, strobe, dual} = 6'h00;
    crb = 8'h00;
    n_errors = 0;
    tests_run = 0;
    n_start = 0;
    n_disc = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(negedge clk);
    chk("busy", 0, 32'(busy));
    chk("wrap bits", 1, 32'(wrap));
    chk("skip", 0, 32'(skip));
    crm(1);
    t_wrap();
    t_prog();
    t_refuse();
    t_protect();
    t_erase();
    t_mode();
    results();
  end
endmodule
`default_nettype wire
